// >>> logic/rtcmf_top.sv
// Multi-function pin driver, oscillator trim and AXI4-Lite register slave
`include "rtcmf_map.svh"

module rtcmf_top (
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	input  wire logic        osc_i,
	input  wire logic        on_backup_i,
	input  wire logic        alarm0_match_i,
	input  wire logic        alarm1_match_i,
	output logic             multi_function_pin_o,
	output logic             multi_function_pin_oe_o,
	output logic             irq_o,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import rtcmf_pkg::*;

	function automatic logic [15:0] rtcmf_add(input logic [14:0] a, input logic [1:0] b);
		return {1'b0, a} + {14'h0000, b};
	endfunction : rtcmf_add

	function automatic logic rtcmf_mapped(input logic [7:0] idx);
		return (idx >= `RTCMF_IDX_CTRL) && (idx <= `RTCMF_IDX_IRQ_MASK);
	endfunction : rtcmf_mapped

	rtcmf_ctrl_s  ctrl;
	rtcmf_trim_s  trim;
	rtcmf_alm_s   alm0;
	rtcmf_alm_s   alm1;
	logic [2:0]   irq_stat;
	logic [2:0]   irq_mask;

	// Pin synchronisers; the first stage is never looked at, and the oscillator's third stage feeds edge detection
	logic         osc_meta;
	logic         osc_sync;
	logic         osc_prev;
	logic         bkp_meta;
	logic         on_backup;

	logic [14:0]  prescaler;
	logic [5:0]   seconds;
	logic [7:0]   trim_pending;

	// AXI write holding registers
	logic         aw_held;
	logic [7:0]   aw_idx;
	logic         w_held;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;

	always_ff @(posedge clk_sys_i) begin
		osc_meta  <= osc_i;
		osc_sync  <= osc_meta;
		osc_prev  <= osc_sync;
		bkp_meta  <= on_backup_i;
		on_backup <= bkp_meta;
	end

	wire osc_tick = osc_sync & ~osc_prev;

	// Prescaler stepping: subtracting freezes the count, adding doubles a step
	wire [1:0]  step_inc   = (trim_pending == 8'h00) ? `RTCMF_INC_NORM :
	                         (trim.sign_add ? `RTCMF_INC_ADD : `RTCMF_INC_SUB);
	wire [15:0] sum_full   = rtcmf_add(prescaler, step_inc);
	wire [15:0] sum_coarse = rtcmf_add({6'h00, prescaler[`RTCMF_BIT_64HZ:0]}, step_inc);
	wire        sec_wrap   = osc_tick & sum_full[15];
	wire        hz64_wrap  = osc_tick & sum_coarse[`RTCMF_BIT_64HZ + 1];
	wire        minute_due = sec_wrap & (seconds == `RTCMF_SEC_LAST);
	// No gating by the backup input: trimming runs on either supply
	wire        trim_due   = (ctrl.coarse_trim_en ? hz64_wrap : minute_due)
	                         & (trim.trim_amount != 7'h00);

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			prescaler    <= 15'h0000;
			seconds      <= 6'h00;
			trim_pending <= 8'h00;
		end else begin
			if (osc_tick) begin
				prescaler <= sum_full[14:0];
			end
			if (sec_wrap) begin
				seconds <= (seconds == `RTCMF_SEC_LAST) ? 6'h00 : seconds + 6'h01;
			end
			if (trim_due) begin
				trim_pending <= {trim.trim_amount, 1'b0};
			end else if (osc_tick && trim_pending != 8'h00) begin
				trim_pending <= trim_pending - 8'h01;
			end
		end
	end

	// Output pin mode selection
	wire mode_sqw   = ctrl.sqw_en;
	wire mode_alarm = ~ctrl.sqw_en & (ctrl.alm0_en | ctrl.alm1_en);
	wire mode_gpo   = ~ctrl.sqw_en & ~ctrl.alm0_en & ~ctrl.alm1_en;
	wire alm_pol    = alm0.polarity;

	wire alarm_single = ctrl.alm0_en ? alm0.match_flag : alm1.match_flag;
	wire alarm_level  = (ctrl.alm0_en & ctrl.alm1_en) ?
	                    (alm_pol ? (alm0.match_flag | alm1.match_flag)
	                             : ~(alm0.match_flag & alm1.match_flag))
	                  : (alm_pol ? alarm_single : ~alarm_single);

	rtcmf_fsel_e fsel;
	assign fsel = rtcmf_fsel_e'(ctrl.freq_sel);

	logic sqw_level;
	always_comb begin
		sqw_level = 1'b0;
		if (ctrl.coarse_trim_en) begin
			sqw_level = prescaler[`RTCMF_BIT_64HZ];
		end else begin
			unique case (fsel)
				RTCMF_FS_1HZ:  sqw_level = prescaler[`RTCMF_BIT_1HZ];
				RTCMF_FS_DIV8: sqw_level = prescaler[`RTCMF_BIT_DIV8];
				RTCMF_FS_DIV4: sqw_level = prescaler[`RTCMF_BIT_DIV4];
				RTCMF_FS_RAW:  sqw_level = osc_sync;
			endcase
		end
	end

	wire next_pin = mode_sqw ? sqw_level : (mode_alarm ? alarm_level : ctrl.out_level);
	// Clock and general-purpose modes release the pin on backup supply
	wire next_oe  = mode_alarm | (~on_backup & (mode_sqw | mode_gpo));

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			multi_function_pin_o    <= 1'b0;
			multi_function_pin_oe_o <= 1'b0;
		end else begin
			multi_function_pin_o    <= next_pin;
			multi_function_pin_oe_o <= next_oe;
		end
	end

	// AXI4-Lite slave
	assign s_axi_awready = ~aw_held;
	assign s_axi_wready  = ~w_held;
	assign s_axi_arready = ~s_axi_rvalid;

	wire aw_take  = s_axi_awvalid & s_axi_awready;
	wire w_take   = s_axi_wvalid & s_axi_wready;
	wire wr_fire  = aw_held & w_held & ~s_axi_bvalid;
	wire wr_lane0 = wr_fire & w_strb[0];
	wire wr_ctrl  = wr_lane0 & (aw_idx == `RTCMF_IDX_CTRL);
	wire wr_trim  = wr_lane0 & (aw_idx == `RTCMF_IDX_TRIM);
	wire wr_alm0  = wr_lane0 & (aw_idx == `RTCMF_IDX_ALM0);
	wire wr_alm1  = wr_lane0 & (aw_idx == `RTCMF_IDX_ALM1);
	wire wr_stat  = wr_lane0 & (aw_idx == `RTCMF_IDX_IRQ_STAT);
	wire wr_mask  = wr_lane0 & (aw_idx == `RTCMF_IDX_IRQ_MASK);
	wire [7:0] wbyte = w_data[7:0];

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			aw_held      <= 1'b0;
			aw_idx       <= 8'h00;
			w_held       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RTCMF_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_idx  <= s_axi_awaddr[9:2];
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= rtcmf_mapped(aw_idx) ? `RTCMF_RESP_OKAY : `RTCMF_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Match flags: hardware set beats a software clear in the same cycle
	wire clr0_keep = wr_alm0 ? wbyte[`RTCMF_ALM_FLAG_BIT] : 1'b1;
	wire clr1_keep = wr_alm1 ? wbyte[`RTCMF_ALM_FLAG_BIT] : 1'b1;
	wire [2:0] events = {trim_due, alarm1_match_i, alarm0_match_i};

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			ctrl     <= rtcmf_ctrl_s'(`RTCMF_CTRL_RST);
			trim     <= rtcmf_trim_s'(`RTCMF_TRIM_RST);
			alm0     <= rtcmf_alm_s'(`RTCMF_ALM_RST);
			alm1     <= rtcmf_alm_s'(`RTCMF_ALM_RST);
			irq_stat <= `RTCMF_IRQ_RST;
			irq_mask <= `RTCMF_IRQ_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl <= rtcmf_ctrl_s'(wbyte);
			end
			if (wr_trim) begin
				trim <= rtcmf_trim_s'(wbyte);
			end
			if (wr_alm0 || wr_alm1) begin
				alm0.polarity <= wbyte[7];
			end
			if (wr_alm0) begin
				alm0.mask    <= wbyte[6:4];
				alm0.weekday <= wbyte[2:0];
			end
			if (wr_alm1) begin
				alm1.mask    <= wbyte[6:4];
				alm1.weekday <= wbyte[2:0];
			end
			alm0.match_flag <= alarm0_match_i | (alm0.match_flag & clr0_keep);
			alm1.match_flag <= alarm1_match_i | (alm1.match_flag & clr1_keep);
			irq_stat <= events | (irq_stat & ~(wr_stat ? wbyte[2:0] : 3'h0));
			if (wr_mask) begin
				irq_mask <= wbyte[2:0];
			end
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	// Read path; the polarity bit is shared, so both alarm registers show it
	wire [7:0] rd_idx = s_axi_araddr[9:2];
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		unique case (rd_idx)
			`RTCMF_IDX_CTRL:     rd_byte = ctrl;
			`RTCMF_IDX_TRIM:     rd_byte = trim;
			`RTCMF_IDX_ALM0:     rd_byte = alm0;
			`RTCMF_IDX_ALM1:     rd_byte = {alm0.polarity, alm1[6:0]};
			`RTCMF_IDX_IRQ_STAT: rd_byte = {5'h00, irq_stat};
			`RTCMF_IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask};
			default:             rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RTCMF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= rtcmf_mapped(rd_idx) ? `RTCMF_RESP_OKAY : `RTCMF_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	property p_sqw_backup_off;
		(mode_sqw && on_backup) |=> !multi_function_pin_oe_o;
	endproperty
	a_sqw_backup_off: assert property (p_sqw_backup_off) else $error("clock on pin in backup");

	property p_raw_passthru;
		(mode_sqw && !ctrl.coarse_trim_en && fsel == RTCMF_FS_RAW)
			|=> (multi_function_pin_o == $past(osc_sync));
	endproperty
	a_raw_passthru: assert property (p_raw_passthru) else $error("raw clock wrong");

	property p_alarm_backup_on;
		(mode_alarm && on_backup) |=> multi_function_pin_oe_o;
	endproperty
	a_alarm_backup_on: assert property (p_alarm_backup_on) else $error("alarm pin off");

	property p_single_alarm;
		(mode_alarm && ctrl.alm0_en && !ctrl.alm1_en)
			|=> (multi_function_pin_o == ($past(alm_pol) ? $past(alm0.match_flag)
			                                             : !$past(alm0.match_flag)));
	endproperty
	a_single_alarm: assert property (p_single_alarm) else $error("single alarm level wrong");

	property p_dual_or;
		(mode_alarm && ctrl.alm0_en && ctrl.alm1_en && alm_pol)
			|=> (multi_function_pin_o == ($past(alm0.match_flag) || $past(alm1.match_flag)));
	endproperty
	a_dual_or: assert property (p_dual_or) else $error("dual OR wrong");

	property p_dual_nand;
		(mode_alarm && ctrl.alm0_en && ctrl.alm1_en && !alm_pol)
			|=> (multi_function_pin_o == !($past(alm0.match_flag) && $past(alm1.match_flag)));
	endproperty
	a_dual_nand: assert property (p_dual_nand) else $error("dual NAND wrong");

	property p_gpo;
		(mode_gpo && !on_backup) |=> (multi_function_pin_oe_o &&
		                              multi_function_pin_o == $past(ctrl.out_level));
	endproperty
	a_gpo: assert property (p_gpo) else $error("gpo level wrong");

	property p_gpo_backup;
		(mode_gpo && on_backup) |=> !multi_function_pin_oe_o;
	endproperty
	a_gpo_backup: assert property (p_gpo_backup) else $error("gpo driven in backup");

	property p_zero_trim;
		(trim.trim_amount == 7'h00 && trim_pending == 8'h00 && !wr_trim)
			|=> (trim_pending == 8'h00);
	endproperty
	a_zero_trim: assert property (p_zero_trim) else $error("trim with zero amount");

	property p_trim_step;
		(osc_tick && trim_pending != 8'h00 && !trim_due)
			|=> (prescaler == $past(prescaler) + ($past(trim.sign_add) ? 15'h0002 : 15'h0000));
	endproperty
	a_trim_step: assert property (p_trim_step) else $error("trim step wrong");

	property p_flag_set_wins;
		alarm0_match_i |=> alm0.match_flag;
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins) else $error("alarm flag lost");

	c_dual_alarm:  cover property (mode_alarm && ctrl.alm0_en && ctrl.alm1_en && !next_pin);
	c_trim_load:   cover property (trim_due ##1 trim_pending != 8'h00);
	c_write_read:  cover property (wr_trim ##[1:4] s_axi_rvalid);
	c_irq:         cover property (!irq_o ##1 irq_o);

endmodule : rtcmf_top

// >>> logic/rtcmf_map.svh
// Register map, field reset values and timing counts of the pin and trim block
// Notes on behaviour
// - Square-wave enable puts a divided oscillator clock on the output pin.
// - Select 00 divides by 32768, 01 by 8, 10 by 4, 11 undivided.
// - No square wave on the pin while running from backup supply.
// - Divided rates carry trimming; undivided selection 11 is untrimmed.
// - Square wave off and an alarm enabled: pin is the alarm interrupt.
// - Alarm interrupt output keeps working on backup supply.
// - One alarm enabled: pin equals its flag, inverted when polarity is 0.
// - Both alarms, polarity 1: pin is OR of both match flags.
// - Both alarms, polarity 0: pin is NAND of both flags.
// - Square wave and both alarms off: pin follows the output level bit.
// - No general-purpose output while running from backup supply.
// - Without coarse trim, adjust once per minute; sign picks add or subtract.
// - Each trim step adds or removes two oscillator pulses per adjustment.
// - Trim amount zero disables trimming whatever the sign.
// - Trimming continues while running from backup supply.
// - Trim register: sign bit 7, amount bits 6..0, read/write, reset zero.
// - Control: level, sqw enable, alarm1, alarm0, ext osc, coarse, freq select.
// - Coarse trim adjusts every 64 Hz cycle; square wave then carries 64 Hz.
`ifndef RTCMF_MAP_SVH
`define RTCMF_MAP_SVH

// Register indices; byte address is four times the index
`define RTCMF_IDX_CTRL      8'h07
`define RTCMF_IDX_TRIM      8'h08
`define RTCMF_IDX_ALM0      8'h09
`define RTCMF_IDX_ALM1      8'h0A
`define RTCMF_IDX_IRQ_STAT  8'h0B
`define RTCMF_IDX_IRQ_MASK  8'h0C

`define RTCMF_CTRL_RST      8'h80
`define RTCMF_TRIM_RST      8'h00
`define RTCMF_ALM_RST       8'h00
`define RTCMF_IRQ_RST       3'h0

// Interrupt status bit positions
`define RTCMF_EV_ALM0       0
`define RTCMF_EV_ALM1       1
`define RTCMF_EV_TRIM       2

// Alarm register flag bit position
`define RTCMF_ALM_FLAG_BIT  3

// Trim period in seconds, and the prescaler geometry in oscillator cycles
`define RTCMF_TRIM_PERIOD_S 6'd60
`define RTCMF_SEC_LAST      (`RTCMF_TRIM_PERIOD_S - 6'd1)
`define RTCMF_BIT_1HZ       14
`define RTCMF_BIT_64HZ      8
`define RTCMF_BIT_DIV8      2
`define RTCMF_BIT_DIV4      1
`define RTCMF_INC_NORM      2'd1
`define RTCMF_INC_ADD       2'd2
`define RTCMF_INC_SUB       2'd0

`define RTCMF_RESP_OKAY     2'b00
`define RTCMF_RESP_SLVERR   2'b10

`endif

// >>> logic/rtcmf_pkg.sv
// Types shared by the pin and trim block
package rtcmf_pkg;

	typedef struct packed {
		logic       out_level;
		logic       sqw_en;
		logic       alm1_en;
		logic       alm0_en;
		logic       ext_osc;
		logic       coarse_trim_en;
		logic [1:0] freq_sel;
	} rtcmf_ctrl_s;

	typedef struct packed {
		logic       sign_add;
		logic [6:0] trim_amount;
	} rtcmf_trim_s;

	typedef struct packed {
		logic       polarity;
		logic [2:0] mask;
		logic       match_flag;
		logic [2:0] weekday;
	} rtcmf_alm_s;

	typedef enum logic [1:0] {
		RTCMF_FS_1HZ,
		RTCMF_FS_DIV8,
		RTCMF_FS_DIV4,
		RTCMF_FS_RAW
	} rtcmf_fsel_e;

endpackage : rtcmf_pkg

// >>> dv/rtcmf_host_model.sv
// Crystal source and host-side sampler of the multi-function pin
module rtcmf_host_model (
	input  wire logic        clk_i,
	input  wire logic        pin_i,
	input  wire logic        oe_i,
	input  wire logic        count_en_i,
	output logic             osc_o,
	output logic [31:0]      edges_o,
	output logic [31:0]      ticks_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] div   = 2'h0;
	logic       osc_q = 1'b0;
	logic       pin_q = 1'b0;

	// Crystal runs free; a half period of two system clocks keeps test windows short
	always @(posedge clk_i) begin
		div   <= div + 2'h1;
		osc_o <= div[1];
		osc_q <= osc_o;
		// A released pin floats, so only driven rising edges are counted
		pin_q <= pin_i & oe_i;
		if (!count_en_i) begin
			edges_o <= 32'h0;
			ticks_o <= 32'h0;
		end else begin
			if (osc_o & !osc_q)
				ticks_o <= ticks_o + 32'h1;
			if (pin_i & oe_i & !pin_q)
				edges_o <= edges_o + 32'h1;
		end
	end

endmodule : rtcmf_host_model

// >>> dv/tb.sv
// Self-checking bench of the pin and trim block over its register bus
`include "rtcmf_map.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rtcmf_pkg::*;

	logic        clk = 1'b0, nrst = 1'b0, backup = 1'b0, cnt_en = 1'b0;
	logic [1:0]  match = 2'h0;
	logic        osc, pin, oe, irq, awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, edges, ticks;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	int          n_fail = 0, total_checks = 0;

	always #4 clk = ~clk;

	rtcmf_top dut_u (.clk_sys_i(clk), .nrst_i(nrst), .osc_i(osc), .on_backup_i(backup),
		.alarm0_match_i(match[0]), .alarm1_match_i(match[1]),
		.multi_function_pin_o(pin), .multi_function_pin_oe_o(oe), .irq_o(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	rtcmf_host_model host_u (.clk_i(clk), .pin_i(pin), .oe_i(oe), .count_en_i(cnt_en),
		.osc_o(osc), .edges_o(edges), .ticks_o(ticks));

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
		total_checks++;
		if (got < lo || got > hi || $isunknown(got)) begin
			n_fail++;
			$display("CHECK FAILED %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_rng

	task automatic hang(input int n);
		if (n > 200) begin
			n_fail++;
			$display("CHECK FAILED %0t bus wait ran out", $time);
			summarize();
		end
	endtask : hang

	// Both channels offered together; each released at the edge that takes it
	task automatic axw(input logic [7:0] idx, input logic [7:0] d);
		bit aw = 0, w = 0, ta, tw;
		int n = 0;
		@(posedge clk);
		awaddr <= {2'h0, idx, 2'h0}; awvalid <= 1'b1;
		wdata <= {24'h0, d}; wvalid <= 1'b1; bready <= 1'b1;
		while (!(aw && w)) begin
			@(negedge clk);
			ta = awready & !aw;
			tw = wready & !w;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			aw |= ta; w |= tw; hang(n++);
		end
		do begin @(negedge clk); hang(n++); end while (bvalid !== 1'b1);
		@(posedge clk);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, `RTCMF_RESP_OKAY});
	endtask : axw

	task automatic axr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
		int n = 0;
		@(posedge clk);
		araddr <= {2'h0, idx, 2'h0}; arvalid <= 1'b1; rready <= 1'b1;
		do begin @(negedge clk); hang(n++); end while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do begin @(negedge clk); hang(n++); end while (rvalid !== 1'b1);
		// Response code and data compared apart so neither is cut off
		chk(rdata, {24'h0, d});
		chk({30'h0, rresp}, {30'h0, r});
		@(posedge clk);
		rready <= 1'b0;
	endtask : axr

	task automatic pulse(input logic [1:0] m);
		@(posedge clk) match <= m;
		@(posedge clk) match <= 2'h0;
	endtask : pulse

	task automatic pin_is(input logic e_pin, input logic e_oe);
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk({oe, pin}, {e_oe, e_pin});
		// Return on a rising edge so the caller drives inputs there
		@(posedge clk);
	endtask : pin_is

	task automatic measure(input int nt, input int lo, input int hi);
		int n = 0;
		@(posedge clk) cnt_en <= 1'b1;
		while (ticks < nt) begin @(posedge clk); if (n++ > nt * 8) hang(999); end
		chk_rng(edges, lo, hi);
		@(posedge clk) cnt_en <= 1'b0;
	endtask : measure

	int          rate_div[3] = '{8, 4, 1};

	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		axr(`RTCMF_IDX_CTRL, `RTCMF_CTRL_RST, `RTCMF_RESP_OKAY);
		axr(`RTCMF_IDX_TRIM, 8'h00, `RTCMF_RESP_OKAY);
		axw(`RTCMF_IDX_TRIM, 8'hA5);
		axr(`RTCMF_IDX_TRIM, 8'hA5, `RTCMF_RESP_OKAY);
		axr(8'h3F, 8'h00, `RTCMF_RESP_SLVERR);
		pin_is(1'b1, 1'b1);
		axw(`RTCMF_IDX_CTRL, 8'h00);
		pin_is(1'b0, 1'b1);
		backup <= 1'b1;
		pin_is(1'b0, 1'b0);
		backup <= 1'b0;
		$display("test registers and general output done");
		// Single alarm: only alarm0 enabled, alarm1 flag must not reach the pin
		axw(`RTCMF_IDX_CTRL, 8'h10);
		axw(`RTCMF_IDX_ALM0, 8'h80);
		pulse(2'h2);
		pin_is(1'b0, 1'b1);
		pulse(2'h1);
		pin_is(1'b1, 1'b1);
		axw(`RTCMF_IDX_ALM0, 8'h00);
		pin_is(1'b1, 1'b1);
		backup <= 1'b1;
		pulse(2'h1);
		pin_is(1'b0, 1'b1);
		backup <= 1'b0;
		axw(`RTCMF_IDX_IRQ_MASK, 8'h01);
		chk({31'h0, irq}, 32'h1);
		axw(`RTCMF_IDX_IRQ_STAT, 8'h07);
		chk({31'h0, irq}, 32'h0);
		$display("test single alarm done");
		axw(`RTCMF_IDX_CTRL, 8'h30);
		for (int f = 0; f < 8; f++) begin
			axw(`RTCMF_IDX_ALM0, {f[2], 7'h0});
			axw(`RTCMF_IDX_ALM1, {f[2], 7'h0});
			pulse(f[1:0]);
			pin_is(f[2] ? (f[0] | f[1]) : !(f[0] & f[1]), 1'b1);
		end
		$display("test dual alarm done");
		axw(`RTCMF_IDX_TRIM, 8'h00);
		for (int k = 0; k < 3; k++) begin
			axw(`RTCMF_IDX_CTRL, 8'h41 + k[7:0]);
			measure(256, 256 / rate_div[k] - 1, 256 / rate_div[k] + 1);
		end
		backup <= 1'b1;
		// The pin keeps toggling behind a released driver, so only the enable is judged
		repeat (6) @(posedge clk);
		@(negedge clk) chk({31'h0, oe}, 32'h0);
		@(posedge clk) backup <= 1'b0;
		$display("test square wave rates done");
		// Coarse trim: zero amount gives no adjustment event
		axw(`RTCMF_IDX_IRQ_MASK, 8'h04);
		// Alarm events of the dual test are still latched in status
		axw(`RTCMF_IDX_IRQ_STAT, 8'h07);
		axw(`RTCMF_IDX_CTRL, 8'h44);
		measure(4128, 7, 9);
		axr(`RTCMF_IDX_IRQ_STAT, 8'h00, `RTCMF_RESP_OKAY);
		axw(`RTCMF_IDX_TRIM, 8'hFF);
		measure(4128, 15, 17);
		chk({31'h0, irq}, 32'h1);
		axw(`RTCMF_IDX_TRIM, 8'h7F);
		measure(4128, 4, 6);
		axw(`RTCMF_IDX_IRQ_STAT, 8'h04);
		backup <= 1'b1;
		// Longer than one subtracting coarse period of 766 oscillator ticks
		repeat (3400) @(posedge clk);
		axr(`RTCMF_IDX_IRQ_STAT, 8'h04, `RTCMF_RESP_OKAY);
		$display("test trimming done");
		summarize();
	end

endmodule : tb
